//--- common/ssf_pkg.sv
// Package with register map, field positions and carriers for the sensor register bank.
package ssf_pkg;
    localparam logic [7:0] ADDR_IDENTITY    = 8'h00;
    localparam logic [7:0] ADDR_REVISION    = 8'h01;
    localparam logic [7:0] ADDR_ERROR       = 8'h02;
    localparam logic [7:0] ADDR_READY       = 8'h03;
    localparam logic [7:0] ADDR_PRESS0      = 8'h04;
    localparam logic [7:0] ADDR_PRESS2      = 8'h06;
    localparam logic [7:0] ADDR_TEMP0       = 8'h07;
    localparam logic [7:0] ADDR_TEMP2       = 8'h09;
    localparam logic [7:0] ADDR_TIME0       = 8'h0C;
    localparam logic [7:0] ADDR_TIME2       = 8'h0E;
    localparam logic [7:0] ADDR_OCCUR       = 8'h10;
    localparam logic [7:0] ADDR_IRQ         = 8'h11;
    localparam logic [7:0] ADDR_LEVEL_LO    = 8'h12;
    localparam logic [7:0] ADDR_LEVEL_HI    = 8'h13;
    localparam logic [7:0] ADDR_QPORT       = 8'h14;
    localparam logic [7:0] ADDR_THRESH_LO   = 8'h15;
    localparam logic [7:0] ADDR_THRESH_HI   = 8'h16;
    localparam logic [7:0] ADDR_FRAME_SETUP = 8'h17;
    localparam logic [7:0] ADDR_SRC_SETUP   = 8'h18;

    // Field positions.
    localparam int ERR_FATAL_BIT   = 0;
    localparam int ERR_CMD_BIT     = 1;
    localparam int ERR_CONF_BIT    = 2;
    localparam int RDY_CMD_BIT     = 4;
    localparam int RDY_PRESS_BIT   = 5;
    localparam int RDY_TEMP_BIT    = 6;
    localparam int OCC_POWERUP_BIT = 0;
    localparam int OCC_BUSCONV_BIT = 1;
    localparam int IRQ_WTM_BIT     = 0;
    localparam int IRQ_FULL_BIT    = 1;
    localparam int IRQ_DRDY_BIT    = 3;
    localparam int FS_ENABLE_BIT   = 0;
    localparam int FS_STOP_BIT     = 1;
    localparam int FS_TIME_BIT     = 2;
    localparam int FS_PRESS_BIT    = 3;
    localparam int FS_TEMP_BIT     = 4;
    localparam int SS_SUB_LSB      = 0;
    localparam int SS_SRC_LSB      = 3;

    // Reset values of the writable and result registers.
    localparam logic [7:0]  RST_THRESH_LO = 8'h01;
    localparam logic [7:0]  RST_THRESH_HI = 8'h00;
    localparam logic [7:0]  RST_FRAME     = 8'h02;
    localparam logic [7:0]  RST_SRC       = 8'h02;
    localparam logic [23:0] RST_RESULT    = 24'h80_0000;
    localparam logic [1:0]  SRC_FILTERED  = 2'b01;

    // Frame headers written ahead of queued samples, and the one read out ahead of the time bytes.
    localparam logic [7:0] HDR_PRESS_TEMP = 8'h94;
    localparam logic [7:0] HDR_PRESS      = 8'h84;
    localparam logic [7:0] HDR_TEMP       = 8'h90;
    localparam logic [7:0] HDR_TIME       = 8'hA0;

    // Register access from the serial front end.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       burst;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssf_access_s;

    // One measurement result from the conversion engine.
    typedef struct packed {
        logic        press_valid;
        logic        temp_valid;
        logic [23:0] press_raw;
        logic [23:0] press_filt;
        logic [23:0] temp_raw;
        logic [23:0] temp_filt;
    } ssf_sample_s;

    typedef enum logic [2:0] {
        SSF_IDLE, SSF_HDR, SSF_P0, SSF_P1, SSF_P2, SSF_T0, SSF_T1, SSF_T2
    } ssf_wstate_e;
endpackage

//--- core/ssf_regs.sv
// Sensor status, result and data queue register bank.
`timescale 1ns/1ps
module ssf_regs
    import ssf_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A,  // Arbitrary value.
    parameter logic [7:0] REVISION_CODE = 8'h11,  // Arbitrary value.
    parameter int         QUEUE_DEPTH   = 512,
    parameter int         LEVEL_W       = 9
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire ssf_access_s bus,
    output logic [7:0]       rdata_q,
    input  wire ssf_sample_s sample,
    input  wire logic        sample_strobe,
    input  wire logic        time_tick,
    input  wire logic        cmd_busy,
    input  wire logic        cmd_fail,
    input  wire logic        conf_invalid,
    input  wire logic        fatal_error,
    input  wire logic        continuous_mode,
    input  wire logic        converting
);
    localparam int AW = $clog2(QUEUE_DEPTH);

    logic [7:0]         mem_q [QUEUE_DEPTH];
    logic [AW-1:0]      wptr_q, rptr_q;
    logic [LEVEL_W-1:0] level_q;
    logic [23:0]        press_q, temp_q, time_q;
    logic [23:0]        press_snap_q, temp_snap_q, time_snap_q;
    logic [LEVEL_W-1:0] level_snap_q;
    logic               cmd_err_q, conf_err_q, drdy_p_q, drdy_t_q;
    logic               por_q, busconv_q, wtm_q, full_q, drdy_irq_q;
    logic [7:0]         thr_lo_q, thr_hi_q, frame_q, src_q;
    logic               burst_q;
    logic [2:0]         sub_cnt_q;
    ssf_wstate_e        wst_q;
    logic               time_pend_q;
    logic [2:0]         tcnt_q;

    wire rd_err   = bus.rd && bus.addr == ADDR_ERROR;
    wire rd_occ   = bus.rd && bus.addr == ADDR_OCCUR;
    wire rd_irq   = bus.rd && bus.addr == ADDR_IRQ;
    wire rd_press = bus.rd && bus.addr >= ADDR_PRESS0 && bus.addr <= ADDR_PRESS2;
    wire rd_temp  = bus.rd && bus.addr >= ADDR_TEMP0 && bus.addr <= ADDR_TEMP2;
    wire rd_port  = bus.rd && bus.addr == ADDR_QPORT;
    wire q_empty  = level_q == '0;
    wire q_full   = level_q == LEVEL_W'(QUEUE_DEPTH - 1);
    wire [LEVEL_W-1:0] threshold = {thr_hi_q[0], thr_lo_q};

    // Error flags: a new event in the read cycle wins over the clear.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_err_q  <= 1'b0;
            conf_err_q <= 1'b0;
        end else begin
            cmd_err_q  <= cmd_fail || (cmd_err_q && !rd_err);
            conf_err_q <= (conf_invalid && continuous_mode) || (conf_err_q && !rd_err);
        end
    end

    // Result registers and their data-ready flags.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            press_q  <= RST_RESULT;
            temp_q   <= RST_RESULT;
            drdy_p_q <= 1'b0;
            drdy_t_q <= 1'b0;
        end else begin
            if (sample_strobe && sample.press_valid) begin
                press_q <= sample.press_filt;
            end
            if (sample_strobe && sample.temp_valid) begin
                temp_q <= sample.temp_filt;
            end
            drdy_p_q <= (sample_strobe && sample.press_valid) || (drdy_p_q && !rd_press);
            drdy_t_q <= (sample_strobe && sample.temp_valid) || (drdy_t_q && !rd_temp);
        end
    end

    // Free-running sensor time.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            time_q <= '0;
        end else if (time_tick) begin
            time_q <= time_q + 24'h00_0001;
        end
    end

    // Snapshot refreshes only outside a burst, so a burst reads one sample.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            burst_q      <= 1'b0;
            press_snap_q <= RST_RESULT;
            temp_snap_q  <= RST_RESULT;
            time_snap_q  <= '0;
            level_snap_q <= '0;
        end else begin
            burst_q <= bus.burst;
            if (!burst_q) begin
                press_snap_q <= press_q;
                temp_snap_q  <= temp_q;
                time_snap_q  <= time_q;
                level_snap_q <= level_q;
            end
        end
    end

    // Event flags; power-up flag comes up out of reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            por_q     <= 1'b1;
            busconv_q <= 1'b0;
        end else begin
            por_q     <= por_q && !rd_occ;
            busconv_q <= ((bus.rd || bus.wr) && converting) || (busconv_q && !rd_occ);
        end
    end

    // Interrupt status, cleared as a whole by its read.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wtm_q      <= 1'b0;
            full_q     <= 1'b0;
            drdy_irq_q <= 1'b0;
        end else begin
            wtm_q      <= (level_q >= threshold && !q_empty) || (wtm_q && !rd_irq);
            full_q     <= q_full || (full_q && !rd_irq);
            drdy_irq_q <= sample_strobe || (drdy_irq_q && !rd_irq);
        end
    end

    // Host-writable configuration.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            thr_lo_q <= RST_THRESH_LO;
            thr_hi_q <= RST_THRESH_HI;
            frame_q  <= RST_FRAME;
            src_q    <= RST_SRC;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_THRESH_LO) begin
                thr_lo_q <= bus.wdata;
            end else if (bus.addr == ADDR_THRESH_HI) begin
                thr_hi_q <= {7'h00, bus.wdata[0]};
            end else if (bus.addr == ADDR_FRAME_SETUP) begin
                frame_q <= {3'h0, bus.wdata[4:0]};
            end else if (bus.addr == ADDR_SRC_SETUP) begin
                src_q <= {3'h0, bus.wdata[4:0]};
            end
        end
    end

    // Queue writer: decimate, then emit header and enabled sample bytes.
    wire         en_p     = frame_q[FS_PRESS_BIT] && sample.press_valid;
    wire         en_t     = frame_q[FS_TEMP_BIT] && sample.temp_valid;
    wire [1:0]   src      = src_q[SS_SRC_LSB +: 2];
    wire         filt     = src == SRC_FILTERED;
    wire [23:0]  p_sel    = filt ? sample.press_filt : sample.press_raw;
    wire [23:0]  t_sel    = filt ? sample.temp_filt : sample.temp_raw;
    wire [2:0]   sub_sh   = src_q[SS_SUB_LSB +: 3];
    wire [7:0]   sub_mask = 8'((9'h001 << sub_sh) - 9'h001);
    wire         take     = sample_strobe && frame_q[FS_ENABLE_BIT] && (en_p || en_t) && wst_q == SSF_IDLE
                            && ((8'(sub_cnt_q) & sub_mask) == 8'h00);
    logic [23:0] p_hold_q, t_hold_q;
    logic        h_p_q, h_t_q;
    logic [7:0]  wbyte;
    logic        wvalid;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sub_cnt_q <= '0;
        end else if (sample_strobe) begin
            sub_cnt_q <= sub_cnt_q + 3'h1;
        end
    end

    // Byte sequencer for one frame.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wst_q    <= SSF_IDLE;
            p_hold_q <= '0;
            t_hold_q <= '0;
            h_p_q    <= 1'b0;
            h_t_q    <= 1'b0;
        end else begin
            case (wst_q)
                SSF_IDLE: begin
                    if (take) begin
                        p_hold_q <= p_sel;
                        t_hold_q <= t_sel;
                        h_p_q    <= en_p;
                        h_t_q    <= en_t;
                        wst_q    <= SSF_HDR;
                    end
                end
                SSF_HDR: wst_q <= h_t_q ? SSF_T0 : SSF_P0;
                SSF_T0:  wst_q <= SSF_T1;
                SSF_T1:  wst_q <= SSF_T2;
                SSF_T2:  wst_q <= h_p_q ? SSF_P0 : SSF_IDLE;
                SSF_P0:  wst_q <= SSF_P1;
                SSF_P1:  wst_q <= SSF_P2;
                default: wst_q <= SSF_IDLE;
            endcase
        end
    end

    // Byte presented to the queue in each sequencer state.
    always_comb begin
        wvalid = 1'b1;
        case (wst_q)
            SSF_HDR: wbyte = (h_p_q && h_t_q) ? HDR_PRESS_TEMP : (h_p_q ? HDR_PRESS : HDR_TEMP);
            SSF_T0:  wbyte = t_hold_q[7:0];
            SSF_T1:  wbyte = t_hold_q[15:8];
            SSF_T2:  wbyte = t_hold_q[23:16];
            SSF_P0:  wbyte = p_hold_q[7:0];
            SSF_P1:  wbyte = p_hold_q[15:8];
            SSF_P2:  wbyte = p_hold_q[23:16];
            default: begin
                wbyte  = 8'h00;
                wvalid = 1'b0;
            end
        endcase
    end

    // Full queue either drops the byte or overwrites the oldest one.
    wire do_write = wvalid && (!q_full || !frame_q[FS_STOP_BIT]);
    wire drop_old = do_write && q_full;
    wire do_read  = rd_port && !q_empty;

    // Queue storage.
    always_ff @(posedge clock) begin
        if (do_write) begin
            mem_q[wptr_q] <= wbyte;
        end
    end

    // Pointers and fill counter.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            level_q <= '0;
        end else begin
            if (do_write) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (do_read || drop_old) begin
                rptr_q <= rptr_q + 1'b1;
            end
            if (do_write && !do_read && !drop_old) begin
                level_q <= level_q + 1'b1;
            end else if (do_read && !do_write) begin
                level_q <= level_q - 1'b1;
            end
        end
    end

    // A time frame follows the last data frame once the queue drains.
    // The pending mark stays up until the last time byte has gone out, or the frame would be cut after its header.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            time_pend_q <= 1'b0;
        end else if (do_read && level_q == LEVEL_W'(1) && frame_q[FS_TIME_BIT]) begin
            time_pend_q <= 1'b1;
        end else if (rd_port && q_empty && tcnt_q == 3'h3) begin
            time_pend_q <= 1'b0;
        end
    end

    // Read data mux; unmapped addresses answer zero.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            tcnt_q  <= '0;
        end else if (bus.rd) begin
            if (bus.addr == ADDR_IDENTITY) begin
                rdata_q <= IDENTITY_CODE;
            end else if (bus.addr == ADDR_REVISION) begin
                rdata_q <= REVISION_CODE;
            end else if (bus.addr == ADDR_ERROR) begin
                rdata_q <= 8'h00;
                rdata_q[ERR_FATAL_BIT] <= fatal_error;
                rdata_q[ERR_CMD_BIT]   <= cmd_err_q;
                rdata_q[ERR_CONF_BIT]  <= conf_err_q;
            end else if (bus.addr == ADDR_READY) begin
                rdata_q <= 8'h00;
                rdata_q[RDY_CMD_BIT]   <= !cmd_busy;
                rdata_q[RDY_PRESS_BIT] <= drdy_p_q;
                rdata_q[RDY_TEMP_BIT]  <= drdy_t_q;
            end else if (rd_press) begin
                rdata_q <= press_snap_q[8*(bus.addr - ADDR_PRESS0) +: 8];
            end else if (rd_temp) begin
                rdata_q <= temp_snap_q[8*(bus.addr - ADDR_TEMP0) +: 8];
            end else if (bus.addr >= ADDR_TIME0 && bus.addr <= ADDR_TIME2) begin
                rdata_q <= time_snap_q[8*(bus.addr - ADDR_TIME0) +: 8];
            end else if (bus.addr == ADDR_OCCUR) begin
                rdata_q <= {6'h00, busconv_q, por_q};
            end else if (bus.addr == ADDR_IRQ) begin
                rdata_q <= {4'h0, drdy_irq_q, 1'b0, full_q, wtm_q};
            end else if (bus.addr == ADDR_LEVEL_LO) begin
                rdata_q <= level_snap_q[7:0];
            end else if (bus.addr == ADDR_LEVEL_HI) begin
                rdata_q <= {7'h00, level_snap_q[8]};
            end else if (bus.addr == ADDR_QPORT) begin
                if (!q_empty) begin
                    rdata_q <= mem_q[rptr_q];
                end else if (time_pend_q) begin
                    rdata_q <= (tcnt_q == 3'h0) ? HDR_TIME : time_snap_q[8*(tcnt_q - 3'h1) +: 8];
                    tcnt_q  <= (tcnt_q == 3'h3) ? 3'h0 : tcnt_q + 3'h1;
                end else begin
                    rdata_q <= 8'h00;
                end
            end else if (bus.addr == ADDR_THRESH_LO) begin
                rdata_q <= thr_lo_q;
            end else if (bus.addr == ADDR_THRESH_HI) begin
                rdata_q <= thr_hi_q;
            end else if (bus.addr == ADDR_FRAME_SETUP) begin
                rdata_q <= frame_q;
            end else if (bus.addr == ADDR_SRC_SETUP) begin
                rdata_q <= src_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // Checks next to the logic.
    cmd_err_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_err && !cmd_fail |=> !cmd_err_q) else $error("command error not cleared by read");
    cmd_err_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        cmd_fail |=> cmd_err_q) else $error("command error not set");
    conf_err_mode_a: assert property (@(posedge clock) disable iff (sys_rst)
        !conf_err_q && !(conf_invalid && continuous_mode) |=> !conf_err_q)
        else $error("config error set outside continuous mode");
    press_rdy_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_press && !sample_strobe |=> !drdy_p_q) else $error("pressure ready not cleared");
    temp_rdy_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_temp && !sample_strobe |=> !drdy_t_q) else $error("temperature ready not cleared");
    event_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        rd_occ && !bus.wr |=> !por_q) else $error("power-up flag not cleared");
    level_dec_a: assert property (@(posedge clock) disable iff (sys_rst)
        do_read && !do_write |=> level_q == $past(level_q) - 1'b1) else $error("level not decremented");
    queue_off_a: assert property (@(posedge clock) disable iff (sys_rst)
        !frame_q[FS_ENABLE_BIT] && wst_q == SSF_IDLE |=> wst_q == SSF_IDLE)
        else $error("queue written while disabled");
    stop_full_a: assert property (@(posedge clock) disable iff (sys_rst)
        q_full && frame_q[FS_STOP_BIT] && !do_read |=> wptr_q == $past(wptr_q))
        else $error("write into full queue");
endmodule

//--- sim/ssf_engine.sv
// Behavioural measurement engine that feeds samples into the register bank.
`timescale 1ns/1ps
module ssf_engine
    import ssf_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        fire,
    input  wire logic [23:0] value,
    output ssf_sample_s      sample,
    output logic             sample_strobe,
    output logic             converting
);
    logic [2:0] cnt_q = 3'h0;

    // A conversion lasts four cycles; the strobe comes only in its last cycle, never on its own.
    always_ff @(posedge clock) begin
        if (fire) begin
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end
    assign converting    = (cnt_q != 3'h0);
    assign sample_strobe = (cnt_q == 3'h1);

    // Raw words are the inverse of the filtered ones, so a wrong source choice shows at once.
    always_comb begin
        sample.press_valid = 1'b1;
        sample.temp_valid  = 1'b1;
        sample.press_filt  = value;
        sample.press_raw   = ~value;
        sample.temp_filt   = value + 24'h11_1111;
        sample.temp_raw    = ~(value + 24'h11_1111);
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the sensor status, result and data queue register bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("CHECK FAILED at %0t: read %h, wanted %h", $time, got, exp); \
    end \
end
module testbench
    import ssf_pkg::*;
;
    localparam logic [7:0] ID_CODE  = 8'h5A;  // Arbitrary value.
    localparam logic [7:0] REV_CODE = 8'h11;  // Arbitrary value.
    logic        clock           = 1'b0;
    logic        sys_rst         = 1'b1;
    ssf_access_s bus_s           = '0;
    logic [7:0]  rdata_q;
    ssf_sample_s sample;
    logic        sample_strobe;
    logic        converting;
    logic        fire            = 1'b0;
    logic [23:0] value           = 24'h12_3456;
    logic        time_tick       = 1'b0;
    logic        cmd_busy        = 1'b0;
    logic        cmd_fail        = 1'b0;
    logic        conf_invalid    = 1'b0;
    logic        fatal_error     = 1'b0;
    logic        continuous_mode = 1'b0;
    int          n_fail          = 0;
    int          num_checks      = 0;
    int          cycles          = 0;
    logic [7:0]  q1[7]  = '{8'h94, 8'h67, 8'h45, 8'h23, 8'h56, 8'h34, 8'h12};
    logic [7:0]  q2[11] = '{8'h94, 8'h98, 8'hBA, 8'hDC, 8'hA9, 8'hCB, 8'hED, 8'hA0, 8'h05, 8'h00, 8'h00};

    ssf_regs #(.IDENTITY_CODE(ID_CODE), .REVISION_CODE(REV_CODE)) DUT (
        .clock(clock), .sys_rst(sys_rst), .bus(bus_s), .rdata_q(rdata_q), .sample(sample),
        .sample_strobe(sample_strobe), .time_tick(time_tick), .cmd_busy(cmd_busy), .cmd_fail(cmd_fail),
        .conf_invalid(conf_invalid), .fatal_error(fatal_error), .continuous_mode(continuous_mode),
        .converting(converting)
    );
    ssf_engine engine (
        .clock(clock), .fire(fire), .value(value), .sample(sample),
        .sample_strobe(sample_strobe), .converting(converting)
    );

    // Clock and a hang guard well above the roughly 1,370 cycles the tests need.
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Each access holds its strobe over one sampling edge, then leaves one idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_s.wr    = 1'b1;
        bus_s.addr  = a;
        bus_s.wdata = d;
        step(1);
        bus_s.wr = 1'b0;
        step(1);
    endtask

    task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        bus_s.rd   = 1'b1;
        bus_s.addr = a;
        step(1);
        d        = rdata_q & m;
        bus_s.rd = 1'b0;
        step(1);
        `CHK(d, e)
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        rdm(a, 8'hFF, e);
    endtask

    task automatic fire_wait();
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        step(14);  // Frame bytes land up to eleven cycles after fire; the snapshot adds one more.
    endtask

    task automatic done(input string s);
        $display("Test %s finished, checks %0d, mismatches %0d", s, num_checks, n_fail);
    endtask

    initial begin
        step(3);
        sys_rst = 1'b0;
        // Reset values, a write to a read-only place and an unmapped read.
        wr(ADDR_IDENTITY, 8'hFF);
        rd_exp(ADDR_IDENTITY, ID_CODE);
        rd_exp(ADDR_PRESS2, 8'h80);
        rd_exp(ADDR_TEMP2, 8'h80);
        rd_exp(ADDR_OCCUR, 8'h01);
        rd_exp(ADDR_OCCUR, 8'h00);
        rd_exp(ADDR_THRESH_LO, 8'h01);
        rd_exp(ADDR_FRAME_SETUP, 8'h02);
        rd_exp(ADDR_SRC_SETUP, 8'h02);
        rd_exp(8'h0A, 8'h00);
        done("reset");
        // Error flags: the configuration check only works in continuous mode.
        fatal_error  = 1'b1;
        cmd_fail     = 1'b1;
        conf_invalid = 1'b1;
        step(1);
        cmd_fail     = 1'b0;
        conf_invalid = 1'b0;
        rd_exp(ADDR_ERROR, 8'h03);
        continuous_mode = 1'b1;
        conf_invalid    = 1'b1;
        step(1);
        conf_invalid = 1'b0;
        fatal_error  = 1'b0;
        rd_exp(ADDR_ERROR, 8'h04);
        rd_exp(ADDR_ERROR, 8'h00);
        cmd_busy = 1'b1;
        step(1);
        rd_exp(ADDR_READY, 8'h00);
        cmd_busy = 1'b0;
        rd_exp(ADDR_READY, 8'h10);
        done("errors");
        // One result, with a bus access made while the conversion runs.
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        rd_exp(ADDR_REVISION, REV_CODE);
        step(8);
        rd_exp(ADDR_READY, 8'h70);
        rd_exp(ADDR_PRESS0, 8'h56);
        rd_exp(ADDR_READY, 8'h50);
        rd_exp(8'h05, 8'h34);
        rd_exp(ADDR_PRESS2, 8'h12);
        rd_exp(8'h08, 8'h45);
        rd_exp(ADDR_READY, 8'h10);
        rd_exp(ADDR_TEMP0, 8'h67);
        rd_exp(ADDR_TEMP2, 8'h23);
        rd_exp(ADDR_OCCUR, 8'h02);
        rd_exp(ADDR_OCCUR, 8'h00);
        repeat (5) begin
            time_tick = 1'b1;
            step(1);
            time_tick = 1'b0;
            step(1);
        end
        rd_exp(ADDR_TIME0, 8'h05);
        rd_exp(ADDR_TIME2, 8'h00);
        done("results");
        // Queue with filtered source and a watermark of seven bytes.
        wr(ADDR_THRESH_HI, 8'h01);
        rd_exp(ADDR_THRESH_HI, 8'h01);
        wr(ADDR_THRESH_HI, 8'h00);
        wr(ADDR_THRESH_LO, 8'h07);
        rd_exp(ADDR_THRESH_LO, 8'h07);
        wr(ADDR_FRAME_SETUP, 8'h19);
        wr(ADDR_SRC_SETUP, 8'h08);
        fire_wait();
        rd_exp(ADDR_LEVEL_LO, 8'h07);
        rd_exp(ADDR_LEVEL_HI, 8'h00);
        rdm(ADDR_IRQ, 8'h03, 8'h01);
        foreach (q1[i]) rd_exp(ADDR_QPORT, q1[i]);
        rd_exp(ADDR_LEVEL_LO, 8'h00);
        rd_exp(ADDR_QPORT, 8'h00);
        rd_exp(ADDR_LEVEL_LO, 8'h00);
        rdm(ADDR_IRQ, 8'h03, 8'h01);
        rdm(ADDR_IRQ, 8'h03, 8'h00);
        wr(ADDR_FRAME_SETUP, 8'h18);
        fire_wait();
        rd_exp(ADDR_LEVEL_LO, 8'h00);
        // Halved rate, reserved source code and a trailing time frame.
        wr(ADDR_FRAME_SETUP, 8'h1D);
        wr(ADDR_SRC_SETUP, 8'h19);
        fire_wait();
        fire_wait();
        rd_exp(ADDR_LEVEL_LO, 8'h07);
        foreach (q2[i]) rd_exp(ADDR_QPORT, q2[i]);
        done("queue");
        // Seventy-three frames of seven bytes fill the queue; stop-on-full then holds it.
        wr(ADDR_SRC_SETUP, 8'h08);
        wr(ADDR_FRAME_SETUP, 8'h1B);
        repeat (73) fire_wait();
        rd_exp(ADDR_LEVEL_LO, 8'hFF);
        rd_exp(ADDR_LEVEL_HI, 8'h01);
        rdm(ADDR_IRQ, 8'h0A, 8'h0A);
        fire_wait();
        rd_exp(ADDR_LEVEL_LO, 8'hFF);
        rd_exp(ADDR_QPORT, 8'h94);
        done("full");
        // A new sample during a burst must not tear the pressure bytes.
        wr(ADDR_FRAME_SETUP, 8'h00);
        bus_s.burst = 1'b1;
        step(1);
        value = 24'h65_4321;
        fire_wait();
        rd_exp(ADDR_PRESS0, 8'h56);
        bus_s.burst = 1'b0;
        step(2);  // The snapshot follows two edges after the burst flag drops.
        rd_exp(ADDR_PRESS0, 8'h21);
        done("burst");
        report_and_stop();
    end
endmodule
